// *** src/dtp_pair.sv ***
// Paired 16-bit timers that also run as one 32-bit timer or counter.
//----------------------------------------------------------------------
//----------------------------------------------------------------------
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defines.svh"
module dtp_pair #(
   parameter int RATIO_A = 1,
   parameter int RATIO_B = 8,
   parameter int RATIO_C = 64,
   parameter int RATIO_D = 256
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port.
   input wire dtp_pkg::dtp_addr_t bus_addr,
   input wire dtp_pkg::dtp_word_t bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output dtp_pkg::dtp_word_t bus_rdata,
   // Pins and core state.
   input wire logic ext_clk_lower,
   input wire logic ext_clk_upper,
   input wire logic gate_lower,
   input wire logic gate_upper,
   input wire logic cpu_idle,
   // Events.
   output logic irq,
   output logic adc_trigger
);
   import dtp_pkg::*;

   //----------------------------------------------------------------
   // Pin synchronisers
   //----------------------------------------------------------------
   // Bit order: gate upper, gate lower, clock upper, clock lower.
   logic [3:0] pins, s1_q, s2_q, s3_q, filt_q, filt_d, rise;

   assign pins = {gate_upper, gate_lower, ext_clk_upper, ext_clk_lower};

   // A level counts only once the second and third stages agree.
   always_comb begin
      filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
      rise = filt_d & ~filt_q;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
         filt_q <= 4'h0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   //----------------------------------------------------------------
   // Registers
   //----------------------------------------------------------------
   dtp_word_t lo_q, lo_d, hi_q, hi_d, hold_q, hold_d;
   dtp_word_t plo_q, plo_d, phi_q, phi_d, clo_q, clo_d, chi_q, chi_d;
   dtp_word_t rdata_q, rdata_d;
   logic [1:0] stat_q, stat_d, ien_q, ien_d, set_ev;
   logic irq_q, irq_d, adc_q, adc_d;

   function automatic logic at(input dtp_addr_t a, input dtp_addr_t ofs);
      at = (a == ofs);
   endfunction : at

   // Raw count event of one timer before its prescaler.
   function automatic logic raw_tick(input dtp_word_t ctl, input logic edge_in,
                                     input logic gate, input logic idle);
      if (!ctl[`DTP_CTL_ENABLE]) begin
         raw_tick = 1'b0;
      end else if (idle && ctl[`DTP_CTL_HALT_IN_IDLE]) begin
         raw_tick = 1'b0;
      end else if (ctl[`DTP_CTL_EXT_CLK]) begin
         raw_tick = edge_in;
      end else if (ctl[`DTP_CTL_GATE]) begin
         raw_tick = gate;
      end else begin
         raw_tick = 1'b1;
      end
   endfunction : raw_tick

   logic mode32, wr_lo, rd_lo;
   assign wr_lo = bus_wr && at(bus_addr, `DTP_OFS_LOW_COUNT);
   assign rd_lo = bus_rd && at(bus_addr, `DTP_OFS_LOW_COUNT);
   assign mode32 = clo_q[`DTP_CTL_MODE32];

   //----------------------------------------------------------------
   // Count sources
   //----------------------------------------------------------------
   logic lo_raw, hi_raw, lo_tick, hi_tick;

   always_comb begin
      lo_raw = raw_tick(clo_q, rise[0], filt_q[2], cpu_idle);
      hi_raw = mode32 ? 1'b0 : raw_tick(chi_q, rise[1], filt_q[3], cpu_idle);
   end

   dtp_prescaler #(
      .RATIO_A(RATIO_A), .RATIO_B(RATIO_B), .RATIO_C(RATIO_C),
      .RATIO_D(RATIO_D), .SYNC_OUT(1'b1)
   ) u_pre_lower (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .run(clo_q[`DTP_CTL_ENABLE]),
      .tick_in(lo_raw),
      .sel(dtp_psel_e'(clo_q[`DTP_CTL_PSEL_LSB +: 2])),
      .tick_out(lo_tick)
   );

   // Upper control is ignored in 32-bit mode.
   dtp_prescaler #(
      .RATIO_A(RATIO_A), .RATIO_B(RATIO_B), .RATIO_C(RATIO_C),
      .RATIO_D(RATIO_D), .SYNC_OUT(1'b0)
   ) u_pre_upper (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .run(chi_q[`DTP_CTL_ENABLE] && !mode32),
      .tick_in(hi_raw),
      .sel(dtp_psel_e'(chi_q[`DTP_CTL_PSEL_LSB +: 2])),
      .tick_out(hi_tick)
   );

   //----------------------------------------------------------------
   // Counters and match
   //----------------------------------------------------------------
   logic match32, match_lo, match_hi, ev_lo, ev_hi;

   always_comb begin
      match32 = ({hi_q, lo_q} == {phi_q, plo_q});
      match_lo = (lo_q == plo_q);
      match_hi = (hi_q == phi_q);
      ev_lo = lo_tick && (mode32 ? match32 : match_lo);
      ev_hi = !mode32 && hi_tick && match_hi;
   end

   always_comb begin
      lo_d = lo_q;
      hi_d = hi_q;
      if (mode32) begin
         // Count and wrap at the period.
         // External edges count the same way.
         if (lo_tick) begin
            {hi_d, lo_d} = match32 ? 32'h0 : {hi_q, lo_q} + 32'h1;
         end
      end else begin
         if (lo_tick) begin
            lo_d = match_lo ? 16'h0000 : lo_q + 16'h0001;
         end
         if (hi_tick) begin
            hi_d = match_hi ? 16'h0000 : hi_q + 16'h0001;
         end
      end
      // Software writes take precedence over a count in the same cycle.
      if (wr_lo) begin
         lo_d = bus_wdata;
         if (mode32) begin
            hi_d = hold_q;
         end
      end
      if (bus_wr && at(bus_addr, `DTP_OFS_HIGH_COUNT)) begin
         hi_d = bus_wdata;
      end
   end

   //----------------------------------------------------------------
   // Register writes, flags and read data
   //----------------------------------------------------------------
   always_comb begin
      hold_d = hold_q;
      plo_d = plo_q;
      phi_d = phi_q;
      clo_d = clo_q;
      chi_d = chi_q;
      ien_d = ien_q;
      // Capture the high word on a low-word read in 32-bit mode.
      if (rd_lo && mode32) begin
         hold_d = hi_q;
      end
      if (bus_wr) begin
         if (at(bus_addr, `DTP_OFS_HOLDING)) begin
            hold_d = bus_wdata;
         end else if (at(bus_addr, `DTP_OFS_LOW_PERIOD)) begin
            plo_d = bus_wdata;
         end else if (at(bus_addr, `DTP_OFS_HIGH_PERIOD)) begin
            phi_d = bus_wdata;
         end else if (at(bus_addr, `DTP_OFS_LOWER_CTL)) begin
            clo_d = bus_wdata & `DTP_LOWER_CTL_MASK;
         end else if (at(bus_addr, `DTP_OFS_UPPER_CTL)) begin
            chi_d = bus_wdata & `DTP_UPPER_CTL_MASK;
         end else if (at(bus_addr, `DTP_OFS_IRQ_ENABLE)) begin
            ien_d = bus_wdata[1:0];
         end
      end
   end

   // A flag set in the cycle of its clear survives the clear.
   always_comb begin
      // 32-bit match uses the upper flag.
      // Split matches use their own flag.
      set_ev[`DTP_IRQ_UPPER] = ev_hi || (mode32 && ev_lo);
      set_ev[`DTP_IRQ_LOWER] = !mode32 && ev_lo;
      stat_d = stat_q;
      if (bus_wr && at(bus_addr, `DTP_OFS_IRQ_CLEAR)) begin
         stat_d = stat_q & ~bus_wdata[1:0];
      end
      stat_d = stat_d | set_ev;
      irq_d = |(stat_d & ien_d);
      adc_d = ev_lo || ev_hi;
   end

   always_comb begin
      rdata_d = 16'h0000;
      if (bus_rd) begin
         if (at(bus_addr, `DTP_OFS_LOW_COUNT)) begin
            rdata_d = lo_q;
         end else if (at(bus_addr, `DTP_OFS_HIGH_COUNT)) begin
            rdata_d = hi_q;
         end else if (at(bus_addr, `DTP_OFS_HOLDING)) begin
            rdata_d = hold_q;
         end else if (at(bus_addr, `DTP_OFS_LOW_PERIOD)) begin
            rdata_d = plo_q;
         end else if (at(bus_addr, `DTP_OFS_HIGH_PERIOD)) begin
            rdata_d = phi_q;
         end else if (at(bus_addr, `DTP_OFS_LOWER_CTL)) begin
            rdata_d = clo_q;
         end else if (at(bus_addr, `DTP_OFS_UPPER_CTL)) begin
            rdata_d = chi_q;
         end else if (at(bus_addr, `DTP_OFS_IRQ_STATUS)) begin
            rdata_d = {14'h0000, stat_q};
         end else if (at(bus_addr, `DTP_OFS_IRQ_ENABLE)) begin
            rdata_d = {14'h0000, ien_q};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lo_q <= `DTP_RST_COUNT;
         hi_q <= `DTP_RST_COUNT;
         hold_q <= `DTP_RST_COUNT;
         plo_q <= `DTP_RST_PERIOD;
         phi_q <= `DTP_RST_PERIOD;
         clo_q <= `DTP_RST_CTL;
         chi_q <= `DTP_RST_CTL;
         stat_q <= `DTP_RST_IRQ;
         ien_q <= `DTP_RST_IRQ;
         irq_q <= 1'b0;
         adc_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         lo_q <= lo_d;
         hi_q <= hi_d;
         hold_q <= hold_d;
         plo_q <= plo_d;
         phi_q <= phi_d;
         clo_q <= clo_d;
         chi_q <= chi_d;
         stat_q <= stat_d;
         ien_q <= ien_d;
         irq_q <= irq_d;
         adc_q <= adc_d;
         rdata_q <= rdata_d;
      end
   end

   assign bus_rdata = rdata_q;
   assign irq = irq_q;
   assign adc_trigger = adc_q;

   //----------------------------------------------------------------
   // Assertions
   //----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence wide_match_s;
      mode32 && lo_tick && match32 && !bus_wr;
   endsequence

   sequence split_match_s;
      !mode32 && lo_tick && match_lo && !bus_wr;
   endsequence

   wide_wrap_a: assert property (
      wide_match_s |=> (lo_q == 16'h0000) && (hi_q == 16'h0000))
      else $error("32-bit count did not wrap to zero on match");

   wide_flag_a: assert property (
      wide_match_s |=> stat_q[`DTP_IRQ_UPPER] && adc_q)
      else $error("32-bit match did not set the upper flag");

   wide_irq_a: assert property (
      wide_match_s ##0 ien_q[`DTP_IRQ_UPPER] ##1 !bus_wr |-> irq_q)
      else $error("enabled 32-bit match gave no interrupt");

   trig_pulse_a: assert property (
      (wide_match_s or split_match_s) |=>
      adc_q ##1 (!adc_q || $past(ev_lo || ev_hi)))
      else $error("converter trigger missing after match");

   split_flag_a: assert property (
      split_match_s |=> stat_q[`DTP_IRQ_LOWER] && (lo_q == 16'h0000))
      else $error("split lower match did not set flag and wrap");

   hold_grab_a: assert property (
      rd_lo && mode32 && !bus_wr |=> hold_q == $past(hi_q))
      else $error("high word not captured on low word read");

   hold_load_a: assert property (
      wr_lo && mode32 |=> (hi_q == $past(hold_q)) &&
      (lo_q == $past(bus_wdata)))
      else $error("high word not loaded from holding on low write");

   idle_halt_a: assert property (
      cpu_idle && clo_q[`DTP_CTL_HALT_IN_IDLE] && !bus_wr ##1
      cpu_idle && !bus_wr |=> $stable(lo_q))
      else $error("count moved while halted in idle");

   upper_quiet_a: assert property (
      mode32 && !lo_tick && !bus_wr |=> $stable(hi_q))
      else $error("high word moved without a lower tick");
endmodule : dtp_pair
`default_nettype wire

// *** inc/dtp_defines.svh ***
// Register offsets, field positions and reset values of the timer pair.
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH

`define DTP_OFS_LOW_COUNT 4'h0
`define DTP_OFS_HIGH_COUNT 4'h1
`define DTP_OFS_HOLDING 4'h2
`define DTP_OFS_LOW_PERIOD 4'h3
`define DTP_OFS_HIGH_PERIOD 4'h4
`define DTP_OFS_LOWER_CTL 4'h5
`define DTP_OFS_UPPER_CTL 4'h6
`define DTP_OFS_IRQ_STATUS 4'h7
`define DTP_OFS_IRQ_CLEAR 4'h8
`define DTP_OFS_IRQ_ENABLE 4'h9

`define DTP_CTL_ENABLE 15
`define DTP_CTL_HALT_IN_IDLE 13
`define DTP_CTL_GATE 6
`define DTP_CTL_PSEL_LSB 4
`define DTP_CTL_MODE32 3
`define DTP_CTL_EXT_CLK 1
`define DTP_LOWER_CTL_MASK 16'ha07a
`define DTP_UPPER_CTL_MASK 16'ha072

`define DTP_IRQ_LOWER 0
`define DTP_IRQ_UPPER 1

`define DTP_RST_COUNT 16'h0000
`define DTP_RST_PERIOD 16'hffff
`define DTP_RST_CTL 16'h0000
`define DTP_RST_IRQ 2'h0

`endif

// *** inc/dtp_pkg.sv ***
// Types shared by the timer pair and its prescaler.
package dtp_pkg;
   typedef logic [15:0] dtp_word_t;
   typedef logic [3:0] dtp_addr_t;
   typedef enum logic [1:0] {DTP_PS_A, DTP_PS_B, DTP_PS_C, DTP_PS_D}
      dtp_psel_e;
endpackage : dtp_pkg

// *** src/dtp_prescaler.sv ***
// Count prescaler with optional registered output tick.
`timescale 1ns/1ps
`default_nettype none
module dtp_prescaler #(
   parameter int RATIO_A = 1,
   parameter int RATIO_B = 8,
   parameter int RATIO_C = 64,
   parameter int RATIO_D = 256,
   parameter bit SYNC_OUT = 1'b1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_b,
   // Count events in, divided events out.
   input wire logic run,
   input wire logic tick_in,
   input wire dtp_pkg::dtp_psel_e sel,
   output logic tick_out
);
   import dtp_pkg::*;

   logic [7:0] cnt_q, cnt_d;
   logic hit, sync_q;

   function automatic logic [7:0] limit(input dtp_psel_e s);
      case (s)
         DTP_PS_A: limit = 8'(RATIO_A - 1);
         DTP_PS_B: limit = 8'(RATIO_B - 1);
         DTP_PS_C: limit = 8'(RATIO_C - 1);
         default: limit = 8'(RATIO_D - 1);
      endcase
   endfunction : limit

   always_comb begin
      cnt_d = cnt_q;
      hit = 1'b0;
      if (!run) begin
         cnt_d = 8'h00;
      end else if (tick_in) begin
         if (cnt_q >= limit(sel)) begin
            cnt_d = 8'h00;
            hit = 1'b1;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 8'h00;
         sync_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         sync_q <= hit;
      end
   end

   // The registered form costs one cycle but re-times fast external counts.
   // A tick still in flight when the timer stops is dropped, so it cannot
   // land on the count after the mode has been changed.
   assign tick_out = SYNC_OUT ? (sync_q && run) : hit;
endmodule : dtp_prescaler
`default_nettype wire

// *** tb/dtp_far_side.sv ***
// Far-side model driving the count clock and gate pins of the timer pair.
`timescale 1ns/1ps
`default_nettype none
module dtp_far_side #(
   parameter int HALF = 4
) (
   // Pacing clock.
   input wire logic sys_clk,
   // Pins of the timer pair.
   output logic ext_clk_lower,
   output logic ext_clk_upper,
   output logic gate_lower,
   output logic gate_upper
);
   initial begin
      ext_clk_lower = 1'b0;
      ext_clk_upper = 1'b0;
      gate_lower = 1'b0;
      gate_upper = 1'b0;
   end
   // rising count edges
   // Each phase spans several cycles, since the pins pass a synchroniser.
   task automatic pulse(input bit upper, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         if (upper) ext_clk_upper <= 1'b1;
         else ext_clk_lower <= 1'b1;
         repeat (HALF) @(posedge sys_clk);
         if (upper) ext_clk_upper <= 1'b0;
         else ext_clk_lower <= 1'b0;
         repeat (HALF) @(posedge sys_clk);
      end
   endtask : pulse
   task automatic set_gate(input bit level);
      @(posedge sys_clk);
      gate_lower <= level;
      gate_upper <= level;
   endtask : set_gate
endmodule : dtp_far_side
`default_nettype wire

// *** tb/dual_timer_32bit_pair_bench.sv ***
// Self-checking bench of the paired timer block.
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defines.svh"
module dual_timer_32bit_pair_bench;
   import dtp_pkg::*;
   localparam dtp_word_t EN = 16'h1 << `DTP_CTL_ENABLE;
   localparam dtp_word_t M32 = 16'h1 << `DTP_CTL_MODE32;
   localparam dtp_word_t EXT = 16'h1 << `DTP_CTL_EXT_CLK;
   localparam dtp_word_t GATE = 16'h1 << `DTP_CTL_GATE;
   localparam dtp_word_t HALT = 16'h1 << `DTP_CTL_HALT_IN_IDLE;
   localparam int RATIO [4] = '{1, 8, 64, 256};
   logic sys_clk;
   logic rst_b;
   dtp_addr_t bus_addr;
   dtp_word_t bus_wdata;
   logic bus_wr;
   logic bus_rd;
   dtp_word_t bus_rdata;
   logic ext_clk_lower;
   logic ext_clk_upper;
   logic gate_lower;
   logic gate_upper;
   logic cpu_idle;
   logic irq;
   logic adc_trigger;
   int fail_count;
   int checked;
   integer seed;
   dtp_word_t a, b, c, d, p;
   int n;

   dtp_pair dut (.sys_clk(sys_clk), .rst_b(rst_b), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .ext_clk_lower(ext_clk_lower),
      .ext_clk_upper(ext_clk_upper), .gate_lower(gate_lower),
      .gate_upper(gate_upper), .cpu_idle(cpu_idle), .irq(irq),
      .adc_trigger(adc_trigger));
   dtp_far_side far (.sys_clk(sys_clk), .ext_clk_lower(ext_clk_lower),
      .ext_clk_upper(ext_clk_upper), .gate_lower(gate_lower),
      .gate_upper(gate_upper));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   //----------------------------------------------------------------
   // Bench tasks
   //----------------------------------------------------------------
   task automatic results;
      $display("checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input dtp_addr_t ad, input dtp_word_t dt);
      @(posedge sys_clk);
      bus_addr <= ad;
      bus_wdata <= dt;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask : wr

   task automatic rd(input dtp_addr_t ad, output dtp_word_t dt);
      @(posedge sys_clk);
      bus_addr <= ad;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      dt = bus_rdata;
   endtask : rd

   // Two reads whose strobes are taken two edges apart.
   task automatic delta(output dtp_word_t dd);
      dtp_word_t x, y;
      rd(`DTP_OFS_LOW_COUNT, x);
      rd(`DTP_OFS_LOW_COUNT, y);
      dd = y - x;
   endtask : delta

   // Bounded wait for the trigger; returns the cycles spent.
   task automatic wait_trig(output int cnt);
      cnt = 0;
      do begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end while (adc_trigger !== 1'b1 && cnt < 2000);
      if (cnt >= 2000) begin
         fail_count++;
         $display("unexpected adc_trigger: expected pulse, seen none");
         results();
      end
   endtask : wait_trig

   task automatic clear_counts;
      wr(`DTP_OFS_HOLDING, 16'h0000);
      wr(`DTP_OFS_LOW_COUNT, 16'h0000);
      wr(`DTP_OFS_HIGH_COUNT, 16'h0000);
   endtask : clear_counts

   function automatic dtp_word_t rst_exp(input int i);
      case (i)
         0, 1, 2: return `DTP_RST_COUNT;
         3, 4: return `DTP_RST_PERIOD;
         default: return 16'h0000;
      endcase
   endfunction : rst_exp

   //----------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------
   initial begin
      seed = 32'h2f1a33f1;
      fail_count = 0;
      checked = 0;
      rst_b = 1'b0;
      bus_addr = 4'h0;
      bus_wdata = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      cpu_idle = 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         rd(4'(i), a);
         check("reset value", rst_exp(i), a);
      end
      wr(`DTP_OFS_LOWER_CTL, 16'hffff);
      rd(`DTP_OFS_LOWER_CTL, a);
      check("lower control", `DTP_LOWER_CTL_MASK, a);
      wr(`DTP_OFS_UPPER_CTL, 16'hffff);
      rd(`DTP_OFS_UPPER_CTL, a);
      check("upper control", `DTP_UPPER_CTL_MASK, a);
      wr(`DTP_OFS_IRQ_STATUS, 16'h0003);
      rd(`DTP_OFS_IRQ_STATUS, a);
      check("status write", 16'h0000, a);
      // Coherent 32-bit write while stopped; upper control must not count.
      wr(`DTP_OFS_LOWER_CTL, M32);
      wr(`DTP_OFS_UPPER_CTL, EN);
      a = dtp_word_t'($random(seed));
      b = dtp_word_t'($random(seed));
      wr(`DTP_OFS_HOLDING, a);
      wr(`DTP_OFS_LOW_COUNT, b);
      rd(`DTP_OFS_HIGH_COUNT, c);
      check("high word load", a, c);
      wr(`DTP_OFS_HOLDING, ~a);
      rd(`DTP_OFS_LOW_COUNT, c);
      check("low word held", b, c);
      rd(`DTP_OFS_HOLDING, c);
      check("holding capture", a, c);
      // Carry from the low word into the high word.
      wr(`DTP_OFS_UPPER_CTL, 16'h0000);
      wr(`DTP_OFS_HIGH_PERIOD, 16'hffff);
      wr(`DTP_OFS_LOW_PERIOD, 16'hffff);
      wr(`DTP_OFS_HOLDING, 16'h0000);
      wr(`DTP_OFS_LOW_COUNT, 16'hfffc);
      wr(`DTP_OFS_LOWER_CTL, EN | M32);
      rd(`DTP_OFS_LOW_COUNT, a);
      rd(`DTP_OFS_HOLDING, b);
      rd(`DTP_OFS_LOW_COUNT, c);
      rd(`DTP_OFS_HOLDING, d);
      check("32-bit step", 32'h4, {d, c} - {b, a});
      // 32-bit match, wrap, trigger and interrupt.
      wr(`DTP_OFS_LOWER_CTL, 16'h0000);
      p = 16'h3 + dtp_word_t'($random(seed) & 7);
      wr(`DTP_OFS_HIGH_PERIOD, 16'h0000);
      wr(`DTP_OFS_LOW_PERIOD, p);
      clear_counts();
      wr(`DTP_OFS_IRQ_ENABLE, 16'h0002);
      wr(`DTP_OFS_LOWER_CTL, EN | M32);
      wait_trig(n);
      wait_trig(n);
      check("match interval", p + 1, n);
      check("irq", 1, irq);
      @(posedge sys_clk);
      #1;
      check("trigger width", 0, adc_trigger);
      wr(`DTP_OFS_LOWER_CTL, 16'h0000);
      rd(`DTP_OFS_IRQ_STATUS, a);
      check("32-bit flag", 16'h0002, a);
      wr(`DTP_OFS_IRQ_ENABLE, 16'h0001);
      repeat (2) @(posedge sys_clk);
      #1;
      check("masked irq", 0, irq);
      wr(`DTP_OFS_IRQ_ENABLE, 16'h0002);
      wr(`DTP_OFS_IRQ_CLEAR, 16'h0002);
      rd(`DTP_OFS_IRQ_STATUS, a);
      check("cleared flag", 16'h0000, a);
      check("cleared irq", 0, irq);
      // Split timers, each on its own period and flag.
      for (int t = 0; t < 2; t++) begin
         p = 16'h3 + dtp_word_t'($random(seed) & 7);
         clear_counts();
         wr(4'(`DTP_OFS_LOW_PERIOD + t), p);
         // Prescale ratios B and C on the two timers in turn.
         wr(4'(`DTP_OFS_LOWER_CTL + t),
            EN | (dtp_word_t'(t + 1) << `DTP_CTL_PSEL_LSB));
         wait_trig(n);
         wait_trig(n);
         check("split interval", (p + 1) * RATIO[t + 1], n);
         wr(4'(`DTP_OFS_LOWER_CTL + t), 16'h0000);
         rd(`DTP_OFS_IRQ_STATUS, a);
         check("split flag", 16'h1 << t, a);
         wr(`DTP_OFS_IRQ_CLEAR, 16'h0003);
      end
      // External counting; upper pin must be ignored in 32-bit mode.
      wr(`DTP_OFS_LOW_PERIOD, 16'hffff);
      wr(`DTP_OFS_HIGH_PERIOD, 16'hffff);
      clear_counts();
      wr(`DTP_OFS_UPPER_CTL, EN | EXT);
      wr(`DTP_OFS_LOWER_CTL, EN | M32 | EXT);
      n = 1 + ($random(seed) & 7);
      far.pulse(1'b1, 3);
      far.pulse(1'b0, n);
      repeat (8) @(posedge sys_clk);
      rd(`DTP_OFS_LOW_COUNT, a);
      check("32-bit ext count", n, a);
      rd(`DTP_OFS_HIGH_COUNT, b);
      check("upper pin ignored", 16'h0000, b);
      wr(`DTP_OFS_LOWER_CTL, 16'h0000);
      wr(`DTP_OFS_HIGH_COUNT, 16'h0000);
      wr(`DTP_OFS_UPPER_CTL, EN | EXT);
      far.pulse(1'b1, n);
      repeat (8) @(posedge sys_clk);
      rd(`DTP_OFS_HIGH_COUNT, a);
      check("split ext count", n, a);
      wr(`DTP_OFS_UPPER_CTL, 16'h0000);
      // Gated counting of internal cycles.
      wr(`DTP_OFS_LOWER_CTL, EN | GATE);
      repeat (6) @(posedge sys_clk);
      delta(a);
      check("gate closed", 16'h0000, a);
      far.set_gate(1'b1);
      repeat (6) @(posedge sys_clk);
      delta(a);
      check("gate open", 16'h0002, a);
      far.set_gate(1'b0);
      // Idle halt and resume.
      wr(`DTP_OFS_LOWER_CTL, EN | M32 | HALT);
      @(posedge sys_clk);
      cpu_idle <= 1'b1;
      delta(a);
      check("idle halt", 16'h0000, a);
      @(posedge sys_clk);
      cpu_idle <= 1'b0;
      delta(a);
      check("idle resume", 16'h0002, a);
      wr(`DTP_OFS_LOWER_CTL, EN | M32);
      @(posedge sys_clk);
      cpu_idle <= 1'b1;
      delta(a);
      check("idle run", 16'h0002, a);
      results();
   end
endmodule : dual_timer_32bit_pair_bench
`default_nettype wire
